/* File: inc/alss_pkg.sv */
package alss_pkg;
  // ***************************************************
  // register offsets (byte addresses)
  // ***************************************************
  localparam logic [11:0] ADDR_RESET    = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_SYNTH    = 12'h008;
  localparam logic [11:0] ADDR_LINK     = 12'h00c;
  localparam logic [11:0] ADDR_CAL      = 12'h010;
  localparam logic [11:0] ADDR_TRIGOUT  = 12'h014;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int RST_SOFT_BIT    = 0;
  localparam int ST_INIT_BIT     = 0;
  localparam int ST_TRIM_BIT     = 1;
  localparam int ST_LOCK_BIT     = 2;
  localparam int ST_FG_BIT       = 3;
  localparam int ST_LINK_BIT     = 4;
  localparam int ST_SYNTH_EN_BIT = 5;
  localparam int SY_RESET_BIT    = 0;
  localparam int SY_CALEN_BIT    = 1;
  localparam int SY_BIAS_LSB     = 8;
  localparam int SY_TRIM_LSB     = 16;
  localparam int SY_DIV_LSB      = 24;
  localparam int LK_EN_BIT       = 0;
  localparam int LK_SYNCSEL_BIT  = 1;
  localparam int LK_MODE_LSB     = 8;
  localparam int LK_KM1_LSB      = 16;
  localparam int CA_EN_BIT       = 0;
  localparam int CA_FG_BIT       = 1;
  localparam int CA_OFS_BIT      = 2;
  localparam int CA_SOFT_BIT     = 3;
  localparam int CA_PINEN_BIT    = 4;
  localparam int CA_OVR_BIT      = 5;
  localparam int CA_STSEL_BIT    = 6;
  // ***************************************************
  // reset values and timing
  // ***************************************************
  localparam logic [31:0] SYNTH_RESET_VAL = 32'h0000_0001;
  localparam logic [31:0] CAL_RESET_VAL   = 32'h0000_000a;
  localparam logic [7:0]  BIAS_EXPECTED   = 8'h4a;
  localparam int          CLK_MHZ         = 125;
  localparam int          INIT_TIME_NS    = 1000;
  localparam int          INIT_CYCLES     = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          TRIM_TIME_NS    = 2000;
  localparam int          TRIM_CYCLES     = (TRIM_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          LOCK_TIME_NS    = 1000;
  localparam int          LOCK_CYCLES     = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          CAL_TIME_NS     = 4000;
  localparam int          CAL_CYCLES      = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W           = 16;

  typedef struct packed {
    logic init_done;
    logic trim_done;
    logic lock;
    logic foreground_cal_done_flag;
    logic link_up;
  } alss_status_t;
endpackage

/* File: logic/alss_timer.sv */
`timescale 1ns/1ns
// one-shot countdown: start loads, done pulses when the count reaches one
module alss_timer #(
  parameter int W = 16
) (
  input  wire logic         pclk,    // clock
  input  wire logic         presetn, // async reset, low
  input  wire logic         start,   // load and run
  input  wire logic         abort,   // stop without done
  input  wire logic [W-1:0] load,    // cycles to count
  output logic              busy,    // counting
  output logic              done     // one-cycle pulse at end
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         busy_reg;
  logic         busy_next;
  logic         done_reg;
  logic         done_next;

  if (W < 2) begin
    $error("alss_timer width too small");
  end

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
    end else if (start) begin
      cnt_next  = load;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule

/* File: logic/alss_top.sv */
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
// How it works
// - startup flag set after initialization finishes
// - releasing synth reset starts trim calibration
// - device reports trim done and lock
// - status pin and done flag on finish
// - 8b10b link follows sync; 64b66b ignores
module alss_top
  import alss_pkg::*;
#(
  parameter int CNT_W_P = CNT_W
) (
  input  wire logic               pclk,            // apb clock
  input  wire logic               presetn,         // async reset, low
  input  wire logic               psel,            // apb select
  input  wire logic               penable,         // apb enable
  input  wire logic               pwrite,          // apb direction
  input  wire logic [11:0]        paddr,           // apb byte address
  input  wire logic [31:0]        pwdata,          // apb write data
  output logic      [31:0]        prdata,          // apb read data
  output logic                    pready,          // apb ready
  output logic                    pslverr,         // apb error
  input  wire logic               synth_en_strap,  // synthesizer enable strap
  input  wire logic               sync_single_ended_pin, // receiver sync, single-ended
  input  wire logic               timestamp_diff_pins,   // receiver sync, differential
  input  wire logic               calibration_trigger_pin, // calibration trigger
  output logic                    calibration_status_pin,  // calibration finished
  output alss_pkg::alss_status_t  status_o,        // status flags
  output logic                    link_running     // link state machine active
);
  import alss_pkg::*;

  // ***************************************************
  // state and registers
  // ***************************************************
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_CAL, S_DONE} alss_cal_state_t;

  alss_cal_state_t cal_st_reg, cal_st_next;
  alss_status_t    st_reg, st_next;
  logic [31:0] synth_reg, synth_next;
  logic [31:0] link_reg, link_next;
  logic [31:0] cal_reg, cal_next;
  logic [31:0] trig_reg, trig_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        strap_reg, strap_next;
  logic        init_pend_reg, init_pend_next;
  logic        stat_pin_reg, stat_pin_next;
  logic        run_reg, run_next;
  logic [1:0]  sync_se_ff, sync_df_ff, trig_ff;
  logic        trig_old_reg;

  logic init_start, trim_start, lock_start, cal_start;
  logic init_done, trim_done, lock_done, cal_done, cal_busy;
  logic wr, rd, soft_trig_rise, pin_trig_rise, sync_now, is_8b10b;

  if (CNT_W_P < 8 || CNT_W_P > 32) begin
    $error("alss_top counter width out of range");
  end

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_se_ff   <= 2'h0;
      sync_df_ff   <= 2'h0;
      trig_ff      <= 2'h3;
      trig_old_reg <= 1'b1;
    end else begin
      sync_se_ff   <= {sync_se_ff[0], sync_single_ended_pin};
      sync_df_ff   <= {sync_df_ff[0], timestamp_diff_pins};
      trig_ff      <= {trig_ff[0], calibration_trigger_pin};
      trig_old_reg <= trig_ff[1];
    end
  end

  function automatic logic [CNT_W_P-1:0] cyc(input int n);
    cyc = CNT_W_P'(n);
  endfunction

  // ***************************************************
  // timers for initialization, trim, lock, calibration
  // ***************************************************
  alss_timer #(.W(CNT_W_P)) u_init (.pclk(pclk), .presetn(presetn), .start(init_start), .abort(1'b0),
    .load(cyc(INIT_CYCLES)), .busy(), .done(init_done));
  alss_timer #(.W(CNT_W_P)) u_trim (.pclk(pclk), .presetn(presetn), .start(trim_start),
    .abort(synth_next[SY_RESET_BIT]), .load(cyc(TRIM_CYCLES)), .busy(), .done(trim_done));
  alss_timer #(.W(CNT_W_P)) u_lock (.pclk(pclk), .presetn(presetn), .start(lock_start),
    .abort(synth_next[SY_RESET_BIT]), .load(cyc(LOCK_CYCLES)), .busy(), .done(lock_done));
  alss_timer #(.W(CNT_W_P)) u_cal (.pclk(pclk), .presetn(presetn), .start(cal_start),
    .abort(!cal_next[CA_EN_BIT]), .load(cyc(CAL_CYCLES)), .busy(cal_busy), .done(cal_done));

  assign wr = psel && penable && pwrite && !pready_reg;
  assign rd = psel && penable && !pwrite && !pready_reg;
  assign soft_trig_rise = wr && paddr == ADDR_CAL && pwdata[CA_SOFT_BIT] && !cal_reg[CA_SOFT_BIT];
  assign pin_trig_rise  = cal_reg[CA_PINEN_BIT] && trig_ff[1] && !trig_old_reg;
  assign is_8b10b = link_reg[LK_MODE_LSB+7];
  assign sync_now = link_reg[LK_SYNCSEL_BIT] ? sync_df_ff[1] : sync_se_ff[1];

  // ***************************************************
  // apb slave and flag logic
  // ***************************************************
  always_comb begin
    synth_next     = synth_reg;
    link_next      = link_reg;
    cal_next       = cal_reg;
    trig_next      = trig_reg;
    st_next        = st_reg;
    strap_next     = strap_reg;
    init_pend_next = 1'b0;
    prdata_next    = prdata_reg;
    pready_next    = psel && penable && !pready_reg;
    pslverr_next   = 1'b0;
    init_start     = init_pend_reg;
    trim_start     = 1'b0;
    lock_start     = 1'b0;
    if (wr) begin
      unique case (paddr)
        ADDR_RESET: begin
          if (pwdata[RST_SOFT_BIT]) begin
            synth_next        = SYNTH_RESET_VAL;
            link_next         = '0;
            cal_next          = CAL_RESET_VAL;
            trig_next         = '0;
            st_next           = '0;
            strap_next        = synth_en_strap;
            init_pend_next    = 1'b1;
          end
        end
        ADDR_SYNTH:   synth_next = pwdata;
        ADDR_LINK:    link_next  = pwdata;
        ADDR_CAL:     cal_next   = pwdata;
        ADDR_TRIGOUT: trig_next  = pwdata;
        ADDR_STATUS:  ;
        default:      pslverr_next = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        ADDR_RESET:   prdata_next = 32'h0;
        ADDR_STATUS:  prdata_next = {26'h0, strap_reg, st_reg};
        ADDR_SYNTH:   prdata_next = synth_reg;
        ADDR_LINK:    prdata_next = link_reg;
        ADDR_CAL:     prdata_next = cal_reg;
        ADDR_TRIGOUT: prdata_next = trig_reg;
        default: begin
          prdata_next  = 32'h0;
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (init_done) st_next.init_done = 1'b1;
    if (strap_reg && synth_reg[SY_RESET_BIT] && !synth_next[SY_RESET_BIT]) begin
      st_next.trim_done = 1'b0;
      st_next.lock      = 1'b0;
      if (synth_next[SY_CALEN_BIT]) trim_start = 1'b1;
      else lock_start = 1'b1;
    end
    if (synth_next[SY_RESET_BIT]) begin
      st_next.trim_done = 1'b0;
      st_next.lock      = 1'b0;
    end
    if (trim_done && !synth_next[SY_RESET_BIT]) begin
      st_next.trim_done = 1'b1;
      lock_start        = 1'b1;
    end
    if (lock_done && !synth_next[SY_RESET_BIT]) st_next.lock = 1'b1;
    // done flag, set wins over clear
    if (cal_start) st_next.foreground_cal_done_flag = 1'b0;
    if (cal_done) st_next.foreground_cal_done_flag = 1'b1;
    st_next.link_up = run_next;
  end

  assign cal_start = st_reg.init_done && cal_reg[CA_EN_BIT] && cal_reg[CA_FG_BIT] &&
                     (soft_trig_rise || pin_trig_rise) && !cal_busy;

  // ***************************************************
  // link run state and status pin
  // ***************************************************
  always_comb begin
    run_next      = 1'b0;
    stat_pin_next = stat_pin_reg;
    cal_st_next   = cal_st_reg;
    if (st_reg.init_done && link_reg[LK_EN_BIT]) run_next = is_8b10b ? sync_now : 1'b1;
    unique case (cal_st_reg)
      S_INIT: if (st_reg.init_done) cal_st_next = S_IDLE;
      S_IDLE: if (cal_start) cal_st_next = S_CAL;
      S_CAL: begin
        stat_pin_next = 1'b0;
        if (cal_done) cal_st_next = S_DONE;
        else if (!cal_reg[CA_EN_BIT]) cal_st_next = S_IDLE;
      end
      S_DONE: if (cal_start) cal_st_next = S_CAL;
      default: cal_st_next = S_INIT;
    endcase
    if (cal_done) stat_pin_next = 1'b1;
    if (cal_start) stat_pin_next = 1'b0;
    if (!st_reg.init_done) begin
      cal_st_next   = S_INIT;
      stat_pin_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_reg     <= SYNTH_RESET_VAL;
      link_reg      <= '0;
      cal_reg       <= CAL_RESET_VAL;
      trig_reg      <= '0;
      st_reg        <= '0;
      strap_reg     <= 1'b0;
      init_pend_reg <= 1'b0;
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      stat_pin_reg  <= 1'b0;
      run_reg       <= 1'b0;
      cal_st_reg    <= S_INIT;
    end else begin
      synth_reg     <= synth_next;
      link_reg      <= link_next;
      cal_reg       <= cal_next;
      trig_reg      <= trig_next;
      st_reg        <= st_next;
      strap_reg     <= strap_next;
      init_pend_reg <= init_pend_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      stat_pin_reg  <= stat_pin_next;
      run_reg       <= run_next;
      cal_st_reg    <= cal_st_next;
    end
  end

  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign calibration_status_pin = stat_pin_reg;
  assign status_o               = st_reg;
  assign link_running           = run_reg;

  // ***************************************************
  // assertions
  // ***************************************************
  init_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    init_done |=> st_reg.init_done)
    else $error("startup flag not set after init");
  init_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(init_pend_reg) |-> !st_reg.init_done)
    else $error("startup flag not cleared by soft restart");
  trim_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    trim_start |-> ##[1:2] !st_reg.trim_done)
    else $error("trim flag not cleared on start");
  lock_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_reg.lock) |-> !synth_reg[SY_RESET_BIT])
    else $error("lock reported while synth in reset");
  foreground_cal_done_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_done && !cal_start) |=> st_reg.foreground_cal_done_flag && stat_pin_reg)
    else $error("calibration finish not reported");
  pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    cal_start |=> !stat_pin_reg)
    else $error("status pin high during calibration");
  link_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.init_done && link_reg[LK_EN_BIT] && !is_8b10b) |=> run_reg)
    else $error("64b66b link not running");
  link_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !link_reg[LK_EN_BIT] |=> !run_reg)
    else $error("link runs while disabled");
endmodule

/* File: sim/alss_rx_model.sv */
`timescale 1ns/1ns
// ***************************************************
// receiver side: sync pins and calibration trigger pin
// ***************************************************
module alss_rx_model (
  input  wire logic pclk,                    // clock
  input  wire logic sync_ok,                 // receiver ready for data
  input  wire logic use_diff,                // sync on differential pins
  input  wire logic trig_hi,                 // trigger pin level wanted
  output logic      sync_single_ended_pin,   // single-ended sync
  output logic      timestamp_diff_pins,     // differential sync
  output logic      calibration_trigger_pin  // calibration trigger
);
  initial begin
    sync_single_ended_pin = 1'b1;
    timestamp_diff_pins = 1'b1;
    calibration_trigger_pin = 1'b1;
  end
  always @(posedge pclk) begin
    // sync source choice
    // the unused path shows the inverse so a wrong select is seen
    sync_single_ended_pin <= use_diff ? !sync_ok : sync_ok;
    timestamp_diff_pins <= use_diff ? sync_ok : !sync_ok;
    calibration_trigger_pin <= trig_hi;
  end
endmodule

/* File: sim/tb_alss_top.sv */
`timescale 1ns/1ns
module tb_alss_top;
  import alss_pkg::*;
  // ***************************************************
  // stimulus and observed signals
  // ***************************************************
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [31:0]  prdata;
  logic [31:0]  rdv;
  logic         pready;
  logic         pslverr;
  logic         errv;
  logic         strap = 1'b1;
  logic         sync_ok = 1'b0;
  logic         use_diff = 1'b0;
  logic         trig_hi = 1'b1;
  logic         se_pin;
  logic         diff_pin;
  logic         trig_pin;
  logic         cal_pin;
  logic         link_run;
  alss_status_t st;
  int           errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  wire  [6:0]   obs = {link_run, cal_pin, st};

  always #4 pclk = ~pclk;

  alss_top u_alss_top (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .synth_en_strap         (strap),
    .sync_single_ended_pin  (se_pin),
    .timestamp_diff_pins    (diff_pin),
    .calibration_trigger_pin(trig_pin),
    .calibration_status_pin (cal_pin),
    .status_o               (st),
    .link_running           (link_run)
  );

  alss_rx_model u_alss_rx_model (
    .pclk                   (pclk),
    .sync_ok                (sync_ok),
    .use_diff               (use_diff),
    .trig_hi                (trig_hi),
    .sync_single_ended_pin  (se_pin),
    .timestamp_diff_pins    (diff_pin),
    .calibration_trigger_pin(trig_pin)
  );

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one transfer: setup, access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdv);
    chk({nm, " err"}, 32'h0000_0000, {31'h0, errv});
  endtask

  // obs index: 4 init, 3 trim, 2 lock, 1 fg, 0 link up, 5 cal pin, 6 link running
  task automatic wait_sig(input int idx, input logic v, input int lim);
    int k;
    k = 0;
    while (obs[idx] !== v && k < lim) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk($sformatf("obs bit %0d", idx), {31'h0, v}, {31'h0, obs[idx]});
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status", ADDR_STATUS, 32'h0000_0000);
    rchk("synth", ADDR_SYNTH, SYNTH_RESET_VAL);
    rchk("cal", ADDR_CAL, CAL_RESET_VAL);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    rchk("status ro", ADDR_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, errv});
    chk("unmapped data", 32'h0000_0000, rdv);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("unmapped wr err", 32'h0000_0001, {31'h0, errv});
    apb(1'b1, ADDR_RESET, 32'h0000_0001);
    rchk("init wait", ADDR_STATUS, 32'h0000_0020);
    wait_sig(4, 1'b1, 200);
    apb(1'b1, ADDR_SYNTH, 32'h1200_4a03);
    rchk("synth rb", ADDR_SYNTH, 32'h1200_4a03);
    apb(1'b1, ADDR_SYNTH, 32'h1200_4a02);
    repeat (200) @(posedge pclk);
    chk("trim early", 32'h0000_0000, {31'h0, st.trim_done});
    wait_sig(3, 1'b1, 100);
    wait_sig(2, 1'b1, 200);
    apb(1'b1, ADDR_LINK, 32'h001f_8000);
    apb(1'b1, ADDR_CAL, 32'h0000_0000);
    apb(1'b1, ADDR_CAL, 32'h0000_0002);
    apb(1'b1, ADDR_TRIGOUT, 32'h0000_0005);
    rchk("trigout", ADDR_TRIGOUT, 32'h0000_0005);
    apb(1'b1, ADDR_CAL, 32'h0000_0003);
    apb(1'b1, ADDR_CAL, 32'h0000_0023);
    apb(1'b1, ADDR_LINK, 32'h001f_8001);
    repeat (8) @(posedge pclk);
    chk("link no sync", 32'h0000_0000, {31'h0, link_run});
    sync_ok <= 1'b1;
    wait_sig(6, 1'b1, 8);
    rchk("link rb", ADDR_LINK, 32'h001f_8001);
    use_diff <= 1'b1;
    wait_sig(6, 1'b0, 8);
    apb(1'b1, ADDR_LINK, 32'h001f_8002);
    apb(1'b1, ADDR_LINK, 32'h001f_8003);
    wait_sig(6, 1'b1, 8);
    sync_ok <= 1'b0;
    apb(1'b1, ADDR_LINK, 32'h001f_0802);
    apb(1'b1, ADDR_LINK, 32'h001f_0803);
    wait_sig(6, 1'b1, 8);
    apb(1'b1, ADDR_CAL, 32'h0000_002b);
    repeat (400) @(posedge pclk);
    chk("cal early", 32'h0000_0000, {31'h0, cal_pin});
    wait_sig(5, 1'b1, 200);
    wait_sig(1, 1'b1, 4);
    rchk("all up", ADDR_STATUS, 32'h0000_003f);
    apb(1'b1, ADDR_CAL, 32'h0000_0033);
    trig_hi <= 1'b0;
    repeat (6) @(posedge pclk);
    trig_hi <= 1'b1;
    wait_sig(1, 1'b0, 12);
    wait_sig(5, 1'b1, 600);
    wait_sig(1, 1'b1, 4);
    apb(1'b1, ADDR_SYNTH, 32'h1233_4a01);
    rchk("synth held", ADDR_STATUS, 32'h0000_0033);
    apb(1'b1, ADDR_SYNTH, 32'h1233_4a00);
    wait_sig(2, 1'b1, 200);
    chk("manual trim", 32'h0000_0000, {31'h0, st.trim_done});
    apb(1'b1, ADDR_CAL, 32'h0000_003b);
    apb(1'b1, ADDR_CAL, 32'h0000_003a);
    repeat (600) @(posedge pclk);
    chk("cal abort", 32'h0000_0000, {30'h0, cal_pin, st.foreground_cal_done_flag});
    strap <= 1'b0;
    apb(1'b1, ADDR_RESET, 32'h0000_0001);
    rchk("restart", ADDR_STATUS, 32'h0000_0000);
    wait_sig(4, 1'b1, 200);
    apb(1'b1, ADDR_SYNTH, 32'h1200_4a02);
    repeat (400) @(posedge pclk);
    chk("no trim", 32'h0000_0000, {31'h0, st.trim_done});
    wrap_up();
  end
endmodule
